// File: rtl/lrx_pkg.sv
// Package with opcodes, widths, flag layout and reset values for the executor.
package lrx_pkg;

  // ===========================================================================
  // Widths and reset values
  // ===========================================================================
  localparam int LRX_DATA_W = 8;
  localparam int LRX_ADDR_W = 7;
  localparam int LRX_PC_W = 15;
  localparam logic [7:0] LRX_W_RST = 8'h00;
  localparam logic [14:0] LRX_PC_RST = 15'h0000;
  localparam logic [6:0] LRX_ADDR_RST = 7'h00;
  localparam logic [3:0] LRX_NIB_MASK = 4'hf;

  // ===========================================================================
  // Operation select codes
  // ===========================================================================
  typedef enum logic [2:0] {
    LRX_OP_NONE = 3'h0,
    LRX_OP_LITERAL_RETURN = 3'h1,
    LRX_OP_ROTATE_LEFT = 3'h2,
    LRX_OP_ROTATE_RIGHT = 3'h3,
    LRX_OP_LITERAL_SUBTRACT = 3'h4
  } lrx_op_t;

  // Destination select bit values.
  localparam logic LRX_DEST_ACC = 1'b0;
  localparam logic LRX_DEST_FILE = 1'b1;

  // ===========================================================================
  // Carriers
  // ===========================================================================
  typedef struct packed {
    logic carry;
    logic half_carry_flag;
    logic zero;
  } lrx_flags_t;

  localparam lrx_flags_t LRX_FLAGS_RST = '{carry: 1'b0,
                                           half_carry_flag: 1'b0,
                                           zero: 1'b0};

  typedef struct packed {
    logic valid;
    lrx_op_t op;
    logic [7:0] literal;
    logic [6:0] file_addr;
    logic dest;
  } lrx_instr_t;

  typedef struct packed {
    logic [7:0] result;
    lrx_flags_t flags;
    logic carry_we;
    logic hc_we;
    logic zero_we;
  } lrx_alu_t;

endpackage : lrx_pkg

// File: rtl/lrx_alu.sv
// Combinational arithmetic for rotate and literal subtract operations.
`timescale 1ns/1ps
`default_nettype none
module lrx_alu
  import lrx_pkg::*;
(
  input wire lrx_op_t op,
  input wire logic [7:0] operand,
  input wire logic [7:0] acc,
  input wire logic carry_in,
  output lrx_alu_t res
);

  logic [8:0] diff;
  logic [4:0] nib_diff;

  always_comb begin
    diff = {1'b0, operand} - {1'b0, acc};
    nib_diff = {1'b0, operand[3:0] & LRX_NIB_MASK} - {1'b0, acc[3:0]};
    res = '0;
    unique case (op)
      LRX_OP_ROTATE_LEFT: begin
        res.result = {operand[6:0], carry_in};
        res.flags.carry = operand[7];
        res.carry_we = 1'b1;
      end
      LRX_OP_ROTATE_RIGHT: begin
        res.result = {carry_in, operand[7:1]};
        res.flags.carry = operand[0];
        res.carry_we = 1'b1;
      end
      LRX_OP_LITERAL_SUBTRACT: begin
        res.result = diff[7:0];
        res.flags.carry = ~diff[8];
        res.flags.half_carry_flag = ~nib_diff[4];
        res.flags.zero = (diff[7:0] == 8'h00);
        res.carry_we = 1'b1;
        res.hc_we = 1'b1;
        res.zero_we = 1'b1;
      end
      default: begin
        res.result = operand;
      end
    endcase
  end

endmodule : lrx_alu
`default_nettype wire

// File: rtl/lrx_exec.sv
// Executor for literal return, rotates through carry and literal subtract.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Literal return loads literal into accumulator, flags kept.
// - Literal return pops stack, PC takes return address.
// - Literal return: one word, two cycles, fetch flushed.
// - Rotate left: carry into bit0, bit7 to carry.
// - Rotate destination bit: 0 accumulator, 1 file.
// - Rotate right: carry into bit7, bit0 to carry.
// - Literal subtract: literal minus accumulator into accumulator.
// - Carry, half-carry clear when accumulator part is larger.
module lrx_exec
  import lrx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire lrx_instr_t instr,
  input wire logic [7:0] file_rdata,
  input wire logic [14:0] stack_top_entry,
  output logic [7:0] acc_out,
  output lrx_flags_t flags_out,
  output logic [6:0] file_addr,
  output logic [7:0] file_wdata,
  output logic file_we,
  output logic stack_pop,
  output logic pc_load,
  output logic [14:0] pc_value,
  output logic busy
);

  // ===========================================================================
  // State
  // ===========================================================================
  typedef enum logic {LRX_ST_RUN, LRX_ST_FLUSH} lrx_state_t;

  typedef struct packed {
    lrx_state_t st;
    logic [7:0] acc;
    lrx_flags_t flags;
    logic [6:0] faddr;
    logic [7:0] fwdata;
    logic fwe;
    logic pop;
    logic pcld;
    logic [14:0] pc;
    logic busy;
  } lrx_state_all_t;

  lrx_state_all_t s_q;
  lrx_state_all_t s_d;
  lrx_alu_t alu;
  logic [7:0] alu_operand;
  logic take;

  assign take = instr.valid && (s_q.st == LRX_ST_RUN);
  assign alu_operand = (instr.op == LRX_OP_LITERAL_SUBTRACT) ?
                       instr.literal : file_rdata;

  lrx_alu u_alu (
    .op(instr.op),
    .operand(alu_operand),
    .acc(s_q.acc),
    .carry_in(s_q.flags.carry),
    .res(alu)
  );

  // ===========================================================================
  // Next state
  // ===========================================================================
  always_comb begin
    s_d = s_q;
    s_d.fwe = 1'b0;
    s_d.pop = 1'b0;
    s_d.pcld = 1'b0;
    s_d.busy = 1'b0;
    unique case (s_q.st)
      LRX_ST_RUN: begin
        if (take) begin
          unique case (instr.op)
            LRX_OP_LITERAL_RETURN: begin
              s_d.acc = instr.literal;
              s_d.pop = 1'b1;
              s_d.pcld = 1'b1;
              s_d.pc = stack_top_entry;
              s_d.busy = 1'b1;
              s_d.st = LRX_ST_FLUSH;
            end
            LRX_OP_ROTATE_LEFT, LRX_OP_ROTATE_RIGHT: begin
              s_d.flags.carry = alu.flags.carry;
              if (instr.dest == LRX_DEST_FILE) begin
                s_d.faddr = instr.file_addr;
                s_d.fwdata = alu.result;
                s_d.fwe = 1'b1;
              end else begin
                s_d.acc = alu.result;
              end
            end
            LRX_OP_LITERAL_SUBTRACT: begin
              s_d.acc = alu.result;
              s_d.flags = alu.flags;
            end
            default: begin
              s_d.st = LRX_ST_RUN;
            end
          endcase
        end
      end
      LRX_ST_FLUSH: begin
        s_d.st = LRX_ST_RUN;
      end
    endcase
  end

  // ===========================================================================
  // Registers
  // ===========================================================================
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{st: LRX_ST_RUN, acc: LRX_W_RST, flags: LRX_FLAGS_RST,
               faddr: LRX_ADDR_RST, fwdata: LRX_W_RST, fwe: 1'b0,
               pop: 1'b0, pcld: 1'b0, pc: LRX_PC_RST, busy: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign acc_out = s_q.acc;
  assign flags_out = s_q.flags;
  assign file_addr = s_q.faddr;
  assign file_wdata = s_q.fwdata;
  assign file_we = s_q.fwe;
  assign stack_pop = s_q.pop;
  assign pc_load = s_q.pcld;
  assign pc_value = s_q.pc;
  assign busy = s_q.busy;

endmodule : lrx_exec
`default_nettype wire

// File: tb/lrx_exec_chk.sv
// Checker of the executor port behaviour.
`timescale 1ns/1ps
`default_nettype none
module lrx_exec_chk
  import lrx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire lrx_instr_t instr,
  input wire logic [7:0] file_rdata,
  input wire logic [14:0] stack_top_entry,
  input wire logic [7:0] acc_out,
  input wire lrx_flags_t flags_out,
  input wire logic [6:0] file_addr,
  input wire logic [7:0] file_wdata,
  input wire logic file_we,
  input wire logic stack_pop,
  input wire logic pc_load,
  input wire logic [14:0] pc_value,
  input wire logic busy
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire tk = instr.valid && !busy;
  wire rt = tk && instr.op == LRX_OP_LITERAL_RETURN;
  wire rl = tk && instr.op == LRX_OP_ROTATE_LEFT;
  wire rr = tk && instr.op == LRX_OP_ROTATE_RIGHT;
  wire sb = tk && instr.op == LRX_OP_LITERAL_SUBTRACT;
  a_ret_acc: assert property (rt |=>
    acc_out == $past(instr.literal) && $stable(flags_out)) else $error("ret");
  a_ret_pop: assert property (rt |=>
    stack_pop && pc_load && pc_value == $past(stack_top_entry))
    else $error("pop");
  a_ret_flush: assert property (rt |=> busy ##1 !busy && !stack_pop)
    else $error("flush");
  a_rl_file: assert property (rl && instr.dest |=> file_we &&
    file_addr == $past(instr.file_addr)
    && flags_out.carry == $past(file_rdata[7])
    && file_wdata == {$past(file_rdata[6:0]), $past(flags_out.carry)})
    else $error("rl");
  a_rot_acc: assert property ((rl || rr) && !instr.dest |=>
    !file_we && flags_out[1:0] == $past(flags_out[1:0])) else $error("rot");
  a_rot_wreg: assert property (rl && !instr.dest |=> acc_out ==
    {$past(file_rdata[6:0]), $past(flags_out.carry)}) else $error("rlw");
  a_rr_wreg: assert property (rr && !instr.dest |=> acc_out ==
    {$past(flags_out.carry), $past(file_rdata[7:1])}) else $error("rrw");
  a_rot_keep: assert property ((rl || rr) && instr.dest |=>
    $stable(acc_out)) else $error("keep");
  a_rr_file: assert property (rr && instr.dest |=> file_we &&
    file_wdata == {$past(flags_out.carry), $past(file_rdata[7:1])}
    && flags_out.carry == $past(file_rdata[0])) else $error("rr");
  a_sub_res: assert property (sb |=>
    acc_out == 8'($past(instr.literal) - $past(acc_out))) else $error("sub");
  a_sub_flag: assert property (sb |=> flags_out[2:1] ==
    {$past(acc_out) <= $past(instr.literal),
     $past(acc_out[3:0]) <= $past(instr.literal[3:0])}) else $error("flag");
  a_sub_zero: assert property (sb |=>
    flags_out.zero == (acc_out == 8'h00)) else $error("zero");
  c_ret: cover property (rt);
  c_refuse: cover property (instr.valid && busy);
  c_rot: cover property (rl && instr.dest);
  c_sub: cover property (sb ##1 flags_out.zero);
endmodule : lrx_exec_chk
`default_nettype wire

// File: tb/literal_return_rotate_sub_exec_bench.sv
// Random and corner stimulus bench for the executor.
`timescale 1ns/1ps
`default_nettype none
module literal_return_rotate_sub_exec_bench;
  import lrx_pkg::*;
  logic clk_sys, nrst, file_we, stack_pop, pc_load, busy;
  lrx_instr_t instr;
  logic [7:0] file_rdata, acc_out, file_wdata, w;
  logic [14:0] stack_top_entry, pc_value;
  lrx_flags_t flags_out, f;
  logic [6:0] file_addr;
  int bad_count = 0, check_count = 0, cyc = 0;
  lrx_exec u_dut (.clk_sys, .nrst, .instr, .file_rdata, .stack_top_entry,
    .acc_out, .flags_out, .file_addr, .file_wdata, .file_we, .stack_pop,
    .pc_load, .pc_value, .busy);
  // ==========================================================================
  // Checking
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 3000) begin
      bad_count++;
      end_sim();
    end
  end
  task end_sim;
    $display("checks %0d bad %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task chk(input logic [16:0] s, e, input string n);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  function automatic logic [8:0] rot_exp(input lrx_op_t op,
    input logic [7:0] v, input logic c);
    rot_exp = op == LRX_OP_ROTATE_LEFT ? {v, c} : {v[0], c, v[7:1]};
  endfunction : rot_exp
  task run(input lrx_op_t op, input logic [7:0] k, v, input logic d);
    logic [7:0] r;
    logic [6:0] a;
    logic [14:0] s;
    logic cn;
    a = 7'($urandom);
    s = 15'($urandom);
    instr <= '{1'b1, op, k, a, d};
    file_rdata <= v;
    stack_top_entry <= s;
    @(posedge clk_sys);
    instr.valid <= 1'b0;
    #1;
    {cn, r} = rot_exp(op, v, f.carry);
    if (op == LRX_OP_LITERAL_RETURN) begin
      chk({acc_out, flags_out}, {k, f}, "ret acc");
      chk({stack_pop, pc_load, pc_value}, {2'h3, s}, "ret pc");
      chk(busy, 1'b1, "busy");
      w = k;
    end else if (op == LRX_OP_LITERAL_SUBTRACT) begin
      r = k - w;
      f = '{w <= k, w[3:0] <= k[3:0], r == 8'h00};
      chk(acc_out, r, "sub acc");
      chk(flags_out, f, "sub flags");
      w = r;
    end else begin
      f.carry = cn;
      chk(flags_out, f, "rot flags");
      if (d) chk({file_we, file_addr, file_wdata}, {1'b1, a, r}, "rf");
      else chk({file_we, acc_out}, {1'b0, r}, "racc");
      if (!d) w = r;
    end
    @(posedge clk_sys);
  endtask : run
  initial begin
    instr = '0;
    file_rdata = 8'h00;
    stack_top_entry = 15'h0000;
    nrst = 1'b0;
    w = 8'h00;
    f = LRX_FLAGS_RST;
    void'($urandom(32'h57b8));
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    run(LRX_OP_LITERAL_RETURN, 8'hff, 8'h00, 1'b0);
    run(LRX_OP_LITERAL_SUBTRACT, 8'hff, 8'h00, 1'b0);
    run(LRX_OP_LITERAL_SUBTRACT, 8'h10, 8'h00, 1'b0);
    run(LRX_OP_LITERAL_SUBTRACT, 8'h0f, 8'h00, 1'b0);
    run(LRX_OP_ROTATE_LEFT, 8'h00, 8'h80, 1'b1);
    run(LRX_OP_ROTATE_RIGHT, 8'h00, 8'h01, 1'b0);
    instr <= '{1'b1, LRX_OP_LITERAL_RETURN, 8'h5a, 7'h00, 1'b0};
    @(posedge clk_sys);
    instr <= '{1'b1, LRX_OP_LITERAL_SUBTRACT, 8'h00, 7'h00, 1'b0};
    @(posedge clk_sys);
    instr.valid <= 1'b0;
    #1;
    chk({busy, acc_out, flags_out}, {1'b0, 8'h5a, f}, "refuse");
    w = 8'h5a;
    @(posedge clk_sys);
    repeat (300) run(lrx_op_t'(3'($urandom_range(4, 1))), 8'($urandom),
      8'($urandom), 1'($urandom));
    end_sim();
  end
endmodule : literal_return_rotate_sub_exec_bench
bind lrx_exec lrx_exec_chk u_chk (.clk_sys, .nrst, .instr, .file_rdata,
  .stack_top_entry, .acc_out, .flags_out, .file_addr, .file_wdata, .file_we,
  .stack_pop, .pc_load, .pc_value, .busy);
`default_nettype wire
